// File: rtl/spm_pkg.sv
// spm_pkg: constants and types shared by the serial engine and its byte queue.
// assumes one system clock; all counts are in system clock cycles.
package spm_pkg;

    // ****************************************************************
    // widths and sizes
    // ****************************************************************
    localparam int         WORD_W     = 8;   // bits per serial word
    localparam int         SS_COUNT   = 8;   // slave select outputs
    localparam int         SEL_W      = 3;   // width of the slave number
    localparam int         RATE_W     = 2;   // width of the bit rate code
    localparam int         DIV_W      = 4;   // width of the rate divider
    localparam int         EDGE_W     = 4;   // counts the sixteen clock edges of a word
    localparam int         FIFO_DEPTH = 16;  // words queued for sending

    // ****************************************************************
    // values
    // ****************************************************************
    localparam logic [DIV_W-1:0]    DIV_ONE    = 4'h1;
    localparam logic [DIV_W-1:0]    DIV_ZERO   = 4'h0;
    localparam logic [EDGE_W-1:0]   EDGE_ZERO  = 4'h0;
    localparam logic [EDGE_W-1:0]   EDGE_ONE   = 4'h1;
    localparam logic [EDGE_W-1:0]   EDGE_LAST  = 4'hF;
    localparam logic [SS_COUNT-1:0] SS_ALL_OFF = 8'hFF;
    localparam logic [SS_COUNT-1:0] SS_ONE     = 8'h01;
    localparam logic [WORD_W-1:0]   WORD_ZERO  = 8'h00;

    // bit rate codes: sck is clk_sys divided by 2, 4, 8 or 16
    localparam logic [RATE_W-1:0]   RATE_DIV2  = 2'h0;
    localparam logic [RATE_W-1:0]   RATE_DIV4  = 2'h1;
    localparam logic [RATE_W-1:0]   RATE_DIV8  = 2'h2;
    localparam logic [RATE_W-1:0]   RATE_DIV16 = 2'h3;

    // ****************************************************************
    // engine states
    // ****************************************************************
    typedef enum logic [1:0] {
        SPM_IDLE,
        SPM_XFER,
        SPM_GAP
    } spm_state_t;

endpackage

// File: rtl/spm_stream_if.sv
// spm_stream_if: one valid/ready word stream between the engine and its queue.
// assumes both ends run on the same clock.
`timescale 1ns/10ps
interface spm_stream_if #(
    parameter int WIDTH = 8
);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// File: rtl/spm_fifo.sv
// spm_fifo: word queue with registered read data and valid/ready on both sides.
// assumes DEPTH is a power of two; the output register holds one extra word.
`timescale 1ns/10ps
module spm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic  clk_sys,
    input  wire logic  rst_n,
    spm_stream_if.snk  fill,
    spm_stream_if.src  drain
);

    // ****************************************************************
    // storage and pointers
    // ****************************************************************
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             q_valid;
    logic [WIDTH-1:0] q_data;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             next_q_valid;
    logic [WIDTH-1:0] next_q_data;
    logic             push;
    logic             pop;

    // back-pressure: the filling side stalls once the memory is full
    assign fill.ready  = (count != FULL_CNT);
    assign drain.valid = q_valid;
    assign drain.data  = q_data;

    // next pointers and output stage; memory moves into the output register
    always_comb begin
        push         = fill.valid && fill.ready;
        pop          = (count != '0) && (!q_valid || drain.ready);
        next_wr_ptr  = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr  = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count   = count + (AW+1)'(push) - (AW+1)'(pop);
        next_q_valid = pop ? 1'b1 : (q_valid && !drain.ready);
        next_q_data  = pop ? mem[rd_ptr] : q_data;
    end

    // memory array carries no reset
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= fill.data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wr_ptr  <= '0;
            rd_ptr  <= '0;
            count   <= '0;
            q_valid <= 1'b0;
            q_data  <= '0;
        end else begin
            wr_ptr  <= next_wr_ptr;
            rd_ptr  <= next_rd_ptr;
            count   <= next_count;
            q_valid <= next_q_valid;
            q_data  <= next_q_data;
        end
    end

endmodule

// File: rtl/spm_engine.sv
// spm_engine: serial master engine, eight selects, four modes, four bit rates.
// assumes the host drives the control ports from clk_sys; miso and ss_in_n
// come from pins and are synchronised here. sck is made here from clk_sys.
//
// How it works
// [R1] only this engine drives sck, toggling once per half bit.
// [R2] the host picks one of four sck bit rates with rate_sel.
// [R3] data changes on one sck edge and is sampled on the other.
// [R4] with cpol low, sck rests low outside transfers.
// [R5] with cpol high, sck rests high outside transfers.
// [R6] with cpha low, first bit is valid at first edge after select falls.
// [R7] with cpha high, first bit is valid at the second edge.
// [R8] with cpha low, sck stays idle for the first half bit.
// [R9] with cpha low, select rises and falls again between words.
// [R10] with cpha high, the first edge starts a word; select may stay low.
// [R11] each word shifts eight bits out on mosi and eight in from miso.
// [R12] unselected slaves ignore sck and float miso.
// [R13] at most one slave drives miso per transfer.
// [R14] a low ss_in_n turns off the sck, mosi and select drivers.
// [R15] contention on ss_in_n raises an event and a sticky flag.
// [R16] eight separate active-low slave select outputs.
// [R17] a finished word raises a one-cycle done event.
// [R18] bytes go out as given, with no command or address framing.
// [R19] every received word lands in the receive holding register.
// [R20] every word the host queues is sent on the link unless contention aborts it.
// [R21] master and slave should share polarity and phase.
// [R22] sck is clk_sys divided by two, four, eight or sixteen.
// [R23] contention aborts the word in progress.
// [R24] reset returns all state except the queue memory to its initial values.
// [R25] words travel most significant bit first in both directions.
// [R26] only the one host-chosen select is ever low.
`timescale 1ns/10ps
module spm_engine #(
    parameter int WORD_W   = spm_pkg::WORD_W,
    parameter int SS_COUNT = spm_pkg::SS_COUNT,
    parameter int DEPTH    = spm_pkg::FIFO_DEPTH
) (
    input  wire logic                      clk_sys,
    input  wire logic                      rst_n,
    // configuration
    input  wire logic                      cpol,
    input  wire logic                      cpha,
    input  wire logic [spm_pkg::RATE_W-1:0] rate_sel,
    input  wire logic                      ss_enable,
    input  wire logic [spm_pkg::SEL_W-1:0]  ss_sel,
    // transmit queue
    input  wire logic [WORD_W-1:0]         tx_data,
    input  wire logic                      tx_valid,
    output logic                           tx_ready,
    output logic                           tx_empty,
    // receive holding register
    output logic [WORD_W-1:0]              rx_data,
    output logic                           rx_valid,
    output logic                           rx_full,
    input  wire logic                      rx_ack,
    // status and events
    output logic                           busy,
    output logic                           xfer_done,
    output logic                           contend_evt,
    output logic                           contend_flag,
    input  wire logic                      contend_clr,
    // serial pins
    output logic                           sck,
    output logic                           mosi,
    output logic                           drv_oe,
    output logic [SS_COUNT-1:0]            ss_n,
    input  wire logic                      miso,
    input  wire logic                      ss_in_n
);

    // ****************************************************************
    // transmit queue
    // ****************************************************************
    spm_stream_if #(.WIDTH(WORD_W)) host_if ();
    spm_stream_if #(.WIDTH(WORD_W)) eng_if ();

    assign host_if.valid = tx_valid;
    assign host_if.data  = tx_data;
    assign tx_ready      = host_if.ready;

    spm_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (DEPTH)
    ) u_txq (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .fill    (host_if.snk),
        .drain   (eng_if.src)
    );

    // nothing is waiting for the engine to pick up
    assign tx_empty = !eng_if.valid;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic miso_m;
    logic miso_s;
    logic ssin_m;
    logic ssin_s;
    logic ssin_d;

    // first stages are read only by second stages; ssin_d feeds the edge detect
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            miso_m <= 1'b0;
            miso_s <= 1'b0;
            ssin_m <= 1'b1;
            ssin_s <= 1'b1;
            ssin_d <= 1'b1;
        end else begin
            miso_m <= miso;
            miso_s <= miso_m;
            ssin_m <= ss_in_n;
            ssin_s <= ssin_m;
            ssin_d <= ssin_s;
        end
    end

    // ****************************************************************
    // serial engine
    // ****************************************************************
    spm_pkg::spm_state_t         state;
    spm_pkg::spm_state_t         next_state;
    logic [spm_pkg::DIV_W-1:0]   div_cnt;
    logic [spm_pkg::DIV_W-1:0]   next_div_cnt;
    logic [spm_pkg::EDGE_W-1:0]  edge_cnt;
    logic [spm_pkg::EDGE_W-1:0]  next_edge_cnt;
    logic [WORD_W-1:0]           tx_sh;
    logic [WORD_W-1:0]           next_tx_sh;
    logic [WORD_W-1:0]           rx_sh;
    logic [WORD_W-1:0]           next_rx_sh;
    logic [WORD_W-1:0]           next_rx_data;
    logic                        next_rx_valid;
    logic                        next_rx_full;
    logic                        next_xfer_done;
    logic                        next_contend_evt;
    logic                        next_contend_flag;
    logic                        next_sck;
    logic                        next_mosi;
    logic                        next_drv_oe;
    logic [SS_COUNT-1:0]         next_ss_n;
    logic                        cpha_q;
    logic                        next_cpha_q;
    logic [spm_pkg::RATE_W-1:0]  rate_q;
    logic [spm_pkg::RATE_W-1:0]  next_rate_q;
    logic [spm_pkg::SEL_W-1:0]   sel_q;
    logic [spm_pkg::SEL_W-1:0]   next_sel_q;
    logic [spm_pkg::DIV_W-1:0]   half_last;
    logic                        tick;
    logic                        leading;
    logic                        sample_edge;
    logic                        do_load;
    logic                        can_start;
    logic                        contend;
    logic                        contend_set;
    logic [SS_COUNT-1:0]         sel_low;

    // half bit lasts 1, 2, 4 or 8 cycles, so sck runs at clk/2 .. clk/16
    assign half_last = (spm_pkg::DIV_ONE << rate_q) - spm_pkg::DIV_ONE; // [R2] [R22]
    assign tick      = (div_cnt == half_last);
    // even edge index is the leading edge, odd the trailing one
    assign leading   = !edge_cnt[0];
    // cpha low samples on leading edges, cpha high on trailing ones
    assign sample_edge = cpha_q ? !leading : leading; // [R3] [R6] [R7]
    assign contend     = !ssin_s;
    assign contend_set = ssin_d && !ssin_s;
    // a new word may start only with a queued byte, select enabled, no contention
    assign can_start = eng_if.valid && ss_enable;
    // one-hot select pattern, inverted for the active-low pins
    assign sel_low   = spm_pkg::SS_ONE << sel_q; // [R16] [R26]
    assign busy      = (state != spm_pkg::SPM_IDLE);
    assign eng_if.ready = do_load;

    // next values of the word engine, shifters, clock and selects
    always_comb begin
        next_state     = state;
        next_div_cnt   = div_cnt;
        next_edge_cnt  = edge_cnt;
        next_tx_sh     = tx_sh;
        next_rx_sh     = rx_sh;
        next_rx_data   = rx_data;
        next_rx_valid  = 1'b0;
        next_xfer_done = 1'b0;
        next_sck       = sck;
        next_mosi      = mosi;
        next_ss_n      = ss_n;
        next_cpha_q    = cpha_q;
        next_rate_q    = rate_q;
        next_sel_q     = sel_q;
        do_load        = 1'b0;
        if (contend) begin
            // another master is selecting us: drop the word, release the bus
            next_state    = spm_pkg::SPM_IDLE; // [R23]
            next_ss_n     = spm_pkg::SS_ALL_OFF; // [R23]
            next_sck      = cpol;
            next_edge_cnt = spm_pkg::EDGE_ZERO;
            next_div_cnt  = spm_pkg::DIV_ZERO;
        end else begin
            unique case (state)
                spm_pkg::SPM_IDLE: begin
                    // idle level follows cpol while nothing is moving
                    next_sck  = cpol; // [R4] [R5]
                    next_ss_n = spm_pkg::SS_ALL_OFF;
                    do_load   = can_start; // [R20]
                end
                spm_pkg::SPM_XFER: begin
                    next_div_cnt = tick ? spm_pkg::DIV_ZERO : div_cnt + spm_pkg::DIV_ONE;
                    if (tick) begin
                        next_sck      = !sck; // [R1]
                        next_edge_cnt = edge_cnt + spm_pkg::EDGE_ONE;
                        if (sample_edge) begin
                            // msb arrives first, so shift in from the bottom
                            next_rx_sh = {rx_sh[WORD_W-2:0], miso_s}; // [R11] [R25]
                        end else begin
                            // present the next bit on the shifting edge
                            next_mosi  = tx_sh[WORD_W-1]; // [R3] [R25]
                            next_tx_sh = {tx_sh[WORD_W-2:0], 1'b0}; // [R11]
                        end
                        if (edge_cnt == spm_pkg::EDGE_LAST) begin
                            // sck is idle again; cpha low drops the select now so even a
                            // one-cycle gap at the fastest rate frames the next word
                            next_ss_n      = cpha_q ? ss_n : spm_pkg::SS_ALL_OFF; // [R9]
                            next_state     = spm_pkg::SPM_GAP;
                            next_rx_data   = next_rx_sh; // [R19]
                            next_rx_valid  = 1'b1; // [R19]
                            next_xfer_done = 1'b1; // [R17]
                            next_edge_cnt  = spm_pkg::EDGE_ZERO;
                        end
                    end
                end
                spm_pkg::SPM_GAP: begin
                    next_div_cnt = tick ? spm_pkg::DIV_ZERO : div_cnt + spm_pkg::DIV_ONE;
                    // cpha low must frame each word with its own select fall
                    if (!cpha_q) begin
                        next_ss_n = spm_pkg::SS_ALL_OFF; // [R9]
                    end
                    if (tick) begin
                        if (can_start) begin
                            do_load = 1'b1; // [R20]
                        end else begin
                            next_state = spm_pkg::SPM_IDLE;
                            next_ss_n  = spm_pkg::SS_ALL_OFF;
                        end
                    end
                end
            endcase
        end
        if (do_load) begin
            // settings are held for the word so a change cannot tear it
            next_state    = spm_pkg::SPM_XFER;
            next_cpha_q   = cpha; // [R21]
            next_rate_q   = rate_sel;
            next_sel_q    = ss_sel;
            next_div_cnt  = spm_pkg::DIV_ZERO;
            next_edge_cnt = spm_pkg::EDGE_ZERO;
            next_rx_sh    = spm_pkg::WORD_ZERO;
            next_ss_n     = ~(spm_pkg::SS_ONE << ss_sel); // [R16] [R26]
            // byte goes out untouched, no framing added
            if (cpha) begin
                // cpha high: first bit appears on the first edge
                next_tx_sh = eng_if.data; // [R7] [R10] [R18]
            end else begin
                // cpha low: first bit is on mosi a half bit before any edge
                next_mosi  = eng_if.data[WORD_W-1]; // [R6] [R8] [R25]
                next_tx_sh = {eng_if.data[WORD_W-2:0], 1'b0}; // [R18]
            end
        end else if (state == spm_pkg::SPM_GAP && cpha_q && !contend && !tick) begin
            // cpha high may keep the same slave selected across words
            next_ss_n = ~sel_low; // [R10]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state     <= spm_pkg::SPM_IDLE; // [R24]
            div_cnt   <= spm_pkg::DIV_ZERO;
            edge_cnt  <= spm_pkg::EDGE_ZERO;
            tx_sh     <= spm_pkg::WORD_ZERO;
            rx_sh     <= spm_pkg::WORD_ZERO;
            rx_data   <= spm_pkg::WORD_ZERO;
            rx_valid  <= 1'b0;
            xfer_done <= 1'b0;
            sck       <= 1'b0;
            mosi      <= 1'b0;
            ss_n      <= spm_pkg::SS_ALL_OFF;
            cpha_q    <= 1'b0;
            rate_q    <= spm_pkg::RATE_DIV2;
            sel_q     <= '0;
        end else begin
            state     <= next_state;
            div_cnt   <= next_div_cnt;
            edge_cnt  <= next_edge_cnt;
            tx_sh     <= next_tx_sh;
            rx_sh     <= next_rx_sh;
            rx_data   <= next_rx_data;
            rx_valid  <= next_rx_valid;
            xfer_done <= next_xfer_done;
            sck       <= next_sck;
            mosi      <= next_mosi;
            ss_n      <= next_ss_n;
            cpha_q    <= next_cpha_q;
            rate_q    <= next_rate_q;
            sel_q     <= next_sel_q;
        end
    end

    // ****************************************************************
    // status flags and driver enable
    // ****************************************************************
    // sticky flags: a set in the same cycle as the clear wins
    always_comb begin
        next_rx_full      = (rx_full && !rx_ack) || next_rx_valid;
        next_contend_evt  = contend_set; // [R15]
        next_contend_flag = (contend_flag && !contend_clr) || contend_set; // [R15]
        // drivers follow the synchronised contention input
        next_drv_oe       = !contend; // [R14]
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rx_full      <= 1'b0;
            contend_evt  <= 1'b0;
            contend_flag <= 1'b0;
            drv_oe       <= 1'b0;
        end else begin
            rx_full      <= next_rx_full;
            contend_evt  <= next_contend_evt;
            contend_flag <= next_contend_flag;
            drv_oe       <= next_drv_oe;
        end
    end

endmodule

// File: dv/spm_engine_asserts.sv
// spm_engine_asserts: port-level checks on the serial engine, bound below.
// assumes one clock domain with the synchronous active-low reset.
`timescale 1ns/10ps
module spm_engine_asserts #(
    parameter int SS_COUNT = spm_pkg::SS_COUNT
) (
    input wire logic                       clk_sys,
    input wire logic                       rst_n,
    input wire logic                       cpol,
    input wire logic                       cpha,
    input wire logic [spm_pkg::RATE_W-1:0] rate_sel,
    input wire logic                       busy,
    input wire logic                       xfer_done,
    input wire logic                       rx_valid,
    input wire logic                       rx_full,
    input wire logic                       contend_evt,
    input wire logic                       contend_flag,
    input wire logic                       sck,
    input wire logic                       drv_oe,
    input wire logic [SS_COUNT-1:0]        ss_n,
    input wire logic                       ss_in_n
);
    // ****
    // checks
    // ****
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    ss_onehot_a: assert property ($onehot0(~ss_n)) else $error("two selects low");
    // cpol may just have moved, so wait one settled cycle before comparing
    sck_idle_a: assert property (!busy && !$past(busy) && $past(rst_n) && $stable(cpol)
        |-> sck == cpol) else $error("sck not at idle level");
    first_half_a: assert property ($rose(busy) && !cpha |-> sck == cpol)
        else $error("sck moved in first half bit");
    ss_idle_a: assert property (!busy |-> ss_n == {SS_COUNT{1'b1}})
        else $error("select low while idle");
    gap_high_a: assert property (xfer_done && !cpha |-> ss_n == {SS_COUNT{1'b1}})
        else $error("select not raised between words");
    done_rx_a: assert property (xfer_done |-> rx_valid) else $error("done without data");
    rx_full_a: assert property (rx_valid |-> rx_full) else $error("rx_full not set");
    div2_len_a: assert property ($rose(busy) && rate_sel == spm_pkg::RATE_DIV2
        |-> ##[15:17] xfer_done) else $error("word length wrong at half rate");
    div16_len_a: assert property ($rose(busy) && rate_sel == spm_pkg::RATE_DIV16
        |-> ##[127:129] xfer_done) else $error("word length wrong at slowest rate");
    contend_evt_a: assert property ($fell(ss_in_n) |-> ##[1:4] contend_evt)
        else $error("no contention event");
    contend_flag_a: assert property (contend_evt |=> contend_flag)
        else $error("contention flag not set");
    drv_off_a: assert property ((!ss_in_n) [*4] |-> !drv_oe && !busy)
        else $error("drivers still on under contention");
endmodule
bind spm_engine spm_engine_asserts #(.SS_COUNT(SS_COUNT)) spm_engine_asserts_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .cpol(cpol), .cpha(cpha), .rate_sel(rate_sel),
    .busy(busy), .xfer_done(xfer_done), .rx_valid(rx_valid), .rx_full(rx_full),
    .contend_evt(contend_evt), .contend_flag(contend_flag), .sck(sck), .drv_oe(drv_oe),
    .ss_n(ss_n), .ss_in_n(ss_in_n));

// File: dv/spm_slave_model.sv
// spm_slave_model: behavioural slave on the serial wires, answers any select.
// assumes the bench resolves wire levels; only this model drives miso.
`timescale 1ns/10ps
module spm_slave_model (
    input  wire logic       sck_w,
    input  wire logic [7:0] ss_w_n,
    input  wire logic       mosi_w,
    input  wire logic       cpol,
    input  wire logic       cpha,
    output logic            miso = 1'b0,
    output logic            got = 1'b0,
    output logic [10:0]     got_word
);
    // ****
    // shift state
    // ****
    logic [7:0] sh_out;
    logic [7:0] sh_in;
    logic [2:0] idx;
    int         bits = 0;
    int         n = 0;
    wire        sel = ~&ss_w_n;

    // select falls: fresh word, first bit out at once in phase 0
    always @(posedge sel) begin
        bits = 0;
        sh_out = 8'hC3 ^ n[7:0];
        for (int i = 0; i < 8; i++) if (!ss_w_n[i]) idx = 3'(i);
        if (!cpha) miso = sh_out[7];
    end
    // released line has no pull, so it shows the opposite of the last bit
    always @(negedge sel) miso = ~miso;
    // sample on the leading edge in phase 0, on the trailing edge in phase 1
    always @(sck_w) if (sel) begin
        if ((sck_w != cpol) ^ cpha) begin
            sh_in = {sh_in[6:0], mosi_w};
            bits++;
            if (bits == 8) begin
                got_word = {idx, sh_in};
                n++;
                bits = 0;
                sh_out = 8'hC3 ^ n[7:0];
                got = ~got;
            end
        end else miso = sh_out[7 - bits];
    end
endmodule

// File: dv/tb.sv
// tb: self-checking bench for the serial engine against the slave model.
// assumes package, stream interface, queue and engine compile first.
`timescale 1ns/10ps
module tb;
    // ****
    // signals
    // ****
    logic        clk_sys = 0, rst_n = 0, cpol = 0, cpha = 0, ss_enable = 0;
    logic [1:0]  rate_sel = 0;
    logic [2:0]  ss_sel = 0;
    logic [7:0]  tx_data = 0, rx_data, ss_n, ss_w;
    logic        tx_valid = 0, rx_ack = 0, contend_clr = 0, ss_in_n = 1, miso, got;
    logic        tx_ready, tx_empty, rx_valid, rx_full, busy, xfer_done;
    logic        contend_evt, contend_flag, sck, mosi, drv_oe;
    logic [10:0] got_word, txq[$];
    logic [8:0]  e, rxq[$];
    int          miscompares = 0, checks = 0, nw = 0, cnt;
    bit          ok;

    always #5 clk_sys = ~clk_sys;
    // released selects are pulled up
    assign ss_w = drv_oe ? ss_n : 8'hFF;
    spm_engine spm_engine_i (.clk_sys(clk_sys), .rst_n(rst_n), .cpol(cpol), .cpha(cpha),
        .rate_sel(rate_sel), .ss_enable(ss_enable), .ss_sel(ss_sel), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_empty(tx_empty), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_full(rx_full), .rx_ack(rx_ack), .busy(busy),
        .xfer_done(xfer_done), .contend_evt(contend_evt), .contend_flag(contend_flag),
        .contend_clr(contend_clr), .sck(sck), .mosi(mosi), .drv_oe(drv_oe), .ss_n(ss_n),
        .miso(miso), .ss_in_n(ss_in_n));
    spm_slave_model spm_slave_model_i (.sck_w(drv_oe ? sck : cpol), .ss_w_n(ss_w),
        .mosi_w(drv_oe ? mosi : 1'b1), .cpol(cpol), .cpha(cpha), .miso(miso), .got(got),
        .got_word(got_word));

    // ****
    // tasks
    // ****
    task automatic chk(input string what, input logic [10:0] seen, input logic [10:0] exp);
        checks++;
        if (seen !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
            miscompares++;
        end
    endtask
    task automatic report_and_stop;
        if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // offer a byte for one cycle; tx_ready is stable until the next rising edge
    task automatic push(input logic [7:0] b);
        ok = tx_ready;
        tx_valid = 1'b1;
        tx_data = b;
        if (ok) begin
            txq.push_back({ss_sel, b});
            rxq.push_back({rate_sel[1], 8'hC3 ^ nw[7:0]});
            nw++;
        end
        @(negedge clk_sys);
    endtask
    task automatic wait_idle;
        repeat (4) @(negedge clk_sys);
        for (int i = 0; i < 3000 && (busy !== 1'b0 || tx_empty !== 1'b1); i++) @(negedge clk_sys);
        chk("drained", {tx_empty, busy}, 2'b10);
    endtask

    // ****
    // checkers
    // ****
    always @(got) chk("wire word", got_word, txq.pop_front());
    // miso is synced late, so received data is judged only at the slower rates
    always @(negedge clk_sys) begin
        rx_ack = 1'($urandom_range(1));
        if (rx_valid === 1'b1) begin
            e = rxq.pop_front();
            if (e[8]) chk("rx byte", rx_data, e[7:0]);
        end
    end

    // ****
    // main sequence
    // ****
    initial begin
        void'($urandom(79));
        repeat (4) @(negedge clk_sys);
        rst_n = 1'b1;
        ss_enable = 1'b1;
        // every polarity and phase at every rate, two back-to-back words each
        for (int m = 0; m < 16; m++) begin
            {cpol, cpha, rate_sel} = m[3:0];
            ss_sel = 3'($urandom_range(7));
            repeat (2) push(8'($urandom));
            tx_valid = 1'b0;
            wait_idle();
        end
        // hold the engine off, fill the queue until refused, then drain in phase 1
        ss_enable = 1'b0;
        {cpol, cpha, rate_sel} = 4'h4;
        cnt = 0;
        do begin
            push(8'($urandom));
            cnt += ok;
        end while (ok && cnt < 20);
        tx_valid = 1'b0;
        chk("depth", 11'(cnt), 11'h011);
        ss_enable = 1'b1;
        wait_idle();
        // another master takes the bus mid-word
        rate_sel = 2'h2;
        push(8'h96);
        tx_valid = 1'b0;
        repeat (20) @(negedge clk_sys);
        ss_in_n = 1'b0;
        repeat (6) @(negedge clk_sys);
        chk("abort", {busy, drv_oe, ss_n}, {2'b00, 8'hFF});
        chk("flag", contend_flag, 1'b1);
        ss_in_n = 1'b1;
        void'(txq.pop_back());
        void'(rxq.pop_back());
        nw--;
        contend_clr = 1'b1;
        @(negedge clk_sys);
        contend_clr = 1'b0;
        @(negedge clk_sys);
        chk("flag clear", contend_flag, 1'b0);
        push(8'h3C);
        tx_valid = 1'b0;
        wait_idle();
        chk("left over", txq.size() + rxq.size(), 0);
        report_and_stop();
    end
    // watchdog: the run needs well under 20000 cycles
    initial begin
        #400000;
        miscompares++;
        report_and_stop();
    end
endmodule
